// >>> rtl/sci_flags.sv
// serial port receiver flags, interrupt and dma request logic
module sci_flags (
  input  wire logic        clock,           // 200 mhz module clock
  input  wire logic        rstn,            // async reset, active low
  input  wire logic [2:0]  avs_address,     // word index
  input  wire logic        avs_read,        // read strobe
  input  wire logic        avs_write,       // write strobe
  input  wire logic [31:0] avs_writedata,   // write data
  output logic      [31:0] avs_readdata,    // read data
  output logic             avs_waitrequest, // stall
  input  wire logic        dma_read,        // dma read of data register
  output logic [7:0]       dma_data,        // data to dma
  input  wire logic        char_done,       // receiver: character complete
  input  wire logic [8:0]  char_data,       // receiver: character bits
  input  wire logic        char_noise,      // receiver: noise on a bit
  input  wire logic        char_stop_zero,  // receiver: stop sample zero
  input  wire logic        rx_bit_stb,      // receiver: one bit shifted
  input  wire logic        tx_serial,       // transmitter serial output
  input  wire logic        tx_done,         // transmitter frame finished
  input  wire logic        rx_pin,          // receive pin level
  input  wire logic        port_dir_tx,     // port direction bit, tx pin
  input  wire logic        port_dir_rx,     // port direction bit, rx pin
  input  wire logic        wake_clear,      // wakeup condition seen
  input  wire logic        stop_mode,       // mcu stop mode
  input  wire logic        dbg_break,       // debug break state
  output logic             rx_in,           // serial input to receiver
  output logic             tx_pin_oe,       // tx pin output enable
  output logic             rx_pin_oe,       // rx pin output enable
  output logic             baud_en,         // baud generator enable
  output logic             rx_irq,          // receiver cpu interrupt
  output logic             err_irq,         // error cpu interrupt
  output logic             tx_irq,          // transmitter cpu interrupt
  output logic             dma_rx_req       // receiver dma request
);
  logic [7:0] ctrl1_q, ctrl2_q, ctrl3_q, brk_q, stat_q, stat_d, data_q;
  logic [7:0] ctrl1_d, ctrl2_d;
  logic       armed_q;      // status read seen, first clearing step
  logic [3:0] ones_q;
  logic [1:0] rxs_q;        // rx pin synchroniser
  logic [1:0] sync_q;       // stop, break synchronisers stage one
  logic [1:0] sync2_q;
  logic       ack_q;
  logic [31:0] rdata_q;
  logic       rx_irq_q, err_irq_q, tx_irq_q, dma_q, rxin_q;
  logic       toe_q, roe_q, baud_q;

  // decode and qualify accesses; one wait cycle gives registered read data
  wire req      = (avs_read | avs_write) & ~ack_q;
  wire run      = ~sync2_q[0];
  wire halt     = sync2_q[0];
  wire wr       = avs_write & ack_q;
  wire rd       = avs_read & ack_q;
  wire wr_c1    = wr && avs_address == sci_flags_pkg::OFS_CTRL1;
  wire wr_c2    = wr && avs_address == sci_flags_pkg::OFS_CTRL2;
  wire wr_c3    = wr && avs_address == sci_flags_pkg::OFS_CTRL3;
  wire wr_bk    = wr && avs_address == sci_flags_pkg::OFS_BRKCTL;
  wire rd_st    = rd && avs_address == sci_flags_pkg::OFS_STAT1;
  wire rd_dat   = rd && avs_address == sci_flags_pkg::OFS_DATA;
  wire en       = ctrl1_q[sci_flags_pkg::C1_EN];
  wire dma_on   = ctrl3_q[sci_flags_pkg::C3_DMARX];
  wire rie      = ctrl2_q[sci_flags_pkg::C2_RIE];
  // break protection: flag clears blocked unless clear-enable
  // clear-enable lets clears through, and they stay done
  wire prot     = sync2_q[1] & ~brk_q[sci_flags_pkg::BK_CLR_EN];
  // dma read alone clears full only while dma service is on
  wire dma_clr  = dma_read & dma_on & rie & ~prot;
  // dma read alone touches only full, error flags need step two
  wire any_dat  = rd_dat | dma_read;
  // second step: data read after status read
  wire step2    = armed_q & any_dat & ~prot;
  wire ev       = char_done & run & en;
  wire ovr      = ev & stat_q[sci_flags_pkg::S1_RXF];
  wire par_bad  = ctrl1_q[sci_flags_pkg::C1_PEN] &
                  ((^char_data) ^ ctrl1_q[sci_flags_pkg::C1_PTY]);
  wire [3:0] idle_need = ctrl1_q[sci_flags_pkg::C1_M] ?
                  sci_flags_pkg::IDLE_BITS_9 : sci_flags_pkg::IDLE_BITS_8;
  wire idle_hit = rx_bit_stb & run & en & rxin_q &
                  (ones_q == idle_need - 4'h1);
  wire loop_on  = ctrl1_q[sci_flags_pkg::C1_LOOP];
  wire stby     = ctrl2_q[sci_flags_pkg::C2_RWU];

  // status next value; set always wins over a clear in the same cycle
  always_comb begin
    stat_d = stat_q;
    if (step2 | dma_clr)
      stat_d[sci_flags_pkg::S1_RXF] = 1'b0;
    // error flags clear on the two-step sequence, not on dma alone
    if (step2)
      stat_d[3:0] = 4'h0;
    if (step2)
      stat_d[sci_flags_pkg::S1_IDLE] = 1'b0;
    // load sets full unless the old one is unread
    if (ev & ~ovr)
      stat_d[sci_flags_pkg::S1_RXF] = 1'b1;
    if (ovr)
      stat_d[sci_flags_pkg::S1_OR] = 1'b1;
    if (ev & ~ovr & char_noise)
      stat_d[sci_flags_pkg::S1_NF] = 1'b1;
    if (ev & ~ovr & char_stop_zero)
      stat_d[sci_flags_pkg::S1_FE] = 1'b1;
    if (ev & ~ovr & par_bad)
      stat_d[sci_flags_pkg::S1_PE] = 1'b1;
    // idle after full count of ones
    if (idle_hit)
      stat_d[sci_flags_pkg::S1_IDLE] = 1'b1;
    if (tx_done & run)
      stat_d[sci_flags_pkg::S1_TC] = 1'b1;
    // disabled module shows transmitter empty and complete
    if (~en)
      stat_d[7:6] = 2'h3;
  end

  // control writes; receiver standby cleared by wakeup
  always_comb begin
    ctrl1_d = wr_c1 ? avs_writedata[7:0] : ctrl1_q;
    ctrl2_d = wr_c2 ? avs_writedata[7:0] : ctrl2_q;
    // transmitter and receiver enables only writable with module on
    if (wr_c2 & ~en)
      ctrl2_d[3:2] = ctrl2_q[3:2];
    if (wake_clear & ~wr_c2)
      ctrl2_d[sci_flags_pkg::C2_RWU] = 1'b0;
  end

  // register file and flags; stop mode blocks flag sets, reads still clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl1_q <= sci_flags_pkg::CTRL_RST;
      ctrl2_q <= sci_flags_pkg::CTRL_RST;
      ctrl3_q <= sci_flags_pkg::CTRL_RST;
      brk_q   <= sci_flags_pkg::CTRL_RST;
      stat_q  <= sci_flags_pkg::STAT_RST;
      data_q  <= 8'h00;
      armed_q <= 1'b0;
    end else begin
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
      if (wr_c3)
        ctrl3_q <= avs_writedata[7:0];
      if (wr_bk)
        brk_q <= avs_writedata[7:0];
      stat_q <= stat_d;
      if (ev & ~ovr)
        data_q <= char_data[7:0];
      // a step made before break survives; none armed during it without clear-enable
      if (rd_st & ~prot)
        armed_q <= 1'b1;
      else if (step2)
        armed_q <= 1'b0;
    end
  end

  // idle ones counter runs on each shifted bit
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      ones_q <= 4'h0;
    else if (rx_bit_stb & run)
      ones_q <= (rxin_q & ~idle_hit) ? ones_q + 4'h1 : 4'h0;
  end

  // synchronisers for pin and mode inputs from outside the clock domain
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxs_q   <= 2'h3;
      sync_q  <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      rxs_q   <= {rxs_q[0], rx_pin};
      sync_q  <= {dbg_break, stop_mode};
      sync2_q <= sync_q;
    end
  end

  // bus slave: read data registered in the wait cycle
  wire [7:0] rsel = (avs_address == sci_flags_pkg::OFS_CTRL1)  ? ctrl1_q :
                    (avs_address == sci_flags_pkg::OFS_CTRL2)  ? ctrl2_q :
                    (avs_address == sci_flags_pkg::OFS_CTRL3)  ? ctrl3_q :
                    (avs_address == sci_flags_pkg::OFS_STAT1)  ? stat_q  :
                    (avs_address == sci_flags_pkg::OFS_DATA)   ? data_q  :
                    (avs_address == sci_flags_pkg::OFS_BRKCTL) ? brk_q   :
                    8'h00;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q   <= req;
      rdata_q <= {24'h0, rsel};
    end
  end

  wire rx_src  = (stat_q[sci_flags_pkg::S1_RXF] & rie) |
                 (stat_q[sci_flags_pkg::S1_IDLE] &
                  ctrl2_q[sci_flags_pkg::C2_IDLE_LINE_IRQ_ENABLE]);
  wire err_src = |(stat_q[3:0] & ctrl3_q[3:0]);
  // dma sees any pending full once enable returns
  wire dma_src = stat_q[sci_flags_pkg::S1_RXF] & rie & dma_on & ~stby;
  wire tx_src  = en & ((stat_q[7] & ctrl2_q[7] & ~ctrl3_q[4]) |
                       (stat_q[6] & ctrl2_q[6]));
  wire tx_oe_d = en | port_dir_tx;
  wire rx_oe_d = ~en & port_dir_rx;
  wire rxin_d  = loop_on ? tx_serial : rxs_q[1];

  // requests held in wait mode; outputs registered
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_irq_q  <= 1'b0;
      err_irq_q <= 1'b0;
      tx_irq_q  <= 1'b0;
      dma_q     <= 1'b0;
      rxin_q    <= 1'b1;
      toe_q     <= 1'b0;
      roe_q     <= 1'b0;
      baud_q    <= 1'b0;
    end else begin
      rx_irq_q  <= rx_src & ~dma_on & ~stby;
      err_irq_q <= err_src;
      tx_irq_q  <= tx_src;
      dma_q     <= dma_src;
      rxin_q    <= rxin_d;
      toe_q     <= tx_oe_d;
      roe_q     <= rx_oe_d;
      // baud generator gated by enable, stopped in stop mode
      baud_q    <= en & ~halt;
    end
  end

  assign avs_waitrequest = ~ack_q;
  assign avs_readdata    = rdata_q;
  assign dma_data        = data_q;
  assign rx_irq          = rx_irq_q;
  assign err_irq         = err_irq_q;
  assign tx_irq          = tx_irq_q;
  assign dma_rx_req      = dma_q;
  assign rx_in           = rxin_q;
  assign tx_pin_oe       = toe_q;
  assign rx_pin_oe       = roe_q;
  assign baud_en         = baud_q;

  // checks: request routing, every request answers one cycle late
  chk_dma_no_cpu: assert property (
    @(posedge clock) disable iff (!rstn)
    dma_on |=> !rx_irq) else $error("cpu irq with dma on");

  // full flag with dma on must reach the controller
  chk_full_route: assert property (
    @(posedge clock) disable iff (!rstn)
    stat_q[5] && rie && dma_on && !stby |=> dma_rx_req)
    else $error("dma request missing");

  // full flag with dma off goes to the cpu
  chk_full_cpu: assert property (
    @(posedge clock) disable iff (!rstn)
    stat_q[5] && rie && !dma_on && !stby |=> rx_irq)
    else $error("cpu request missing");

  // a clean load sets full and takes the character
  chk_full_set: assert property (
    @(posedge clock) disable iff (!rstn)
    ev && !ovr |=> stat_q[5] && data_q == $past(char_data[7:0]))
    else $error("character not loaded");

  // overrun keeps the older character
  chk_ovr_keep: assert property (
    @(posedge clock) disable iff (!rstn)
    ovr && !any_dat |=> stat_q[3] && data_q == $past(data_q))
    else $error("overrun lost old data");

  // with overrun standing, later characters still load
  chk_ovr_reload: assert property (
    @(posedge clock) disable iff (!rstn)
    ev && !ovr && stat_q[3] && !step2 |=> stat_q[3] && stat_q[5])
    else $error("load blocked by overrun");

  // ten ones in eight bit mode set idle
  chk_idle_count: assert property (
    @(posedge clock) disable iff (!rstn)
    rx_bit_stb && run && en && rxin_q && ones_q == 4'h9 &&
    !ctrl1_q[sci_flags_pkg::C1_M] |=> stat_q[4])
    else $error("idle not seen");

  // idle alone raises nothing without its enable
  chk_idle_irq: assert property (
    @(posedge clock) disable iff (!rstn)
    !ctrl2_q[sci_flags_pkg::C2_IDLE_LINE_IRQ_ENABLE] && !(stat_q[5] && rie) |=> !rx_irq)
    else $error("idle irq without enable");

  // error request follows each flag and its own enable
  chk_err_irq: assert property (
    @(posedge clock) disable iff (!rstn)
    |(stat_q[3:0] & ctrl3_q[3:0]) |=> err_irq)
    else $error("error irq missing");

  // request drops when no enabled error flag stands
  chk_err_quiet: assert property (
    @(posedge clock) disable iff (!rstn)
    !(|(stat_q[3:0] & ctrl3_q[3:0])) |=> !err_irq)
    else $error("error irq stuck");

  // noise seen on a loaded character
  chk_noise_set: assert property (
    @(posedge clock) disable iff (!rstn)
    ev && !ovr && char_noise |=> stat_q[2])
    else $error("noise flag missing");

  // low stop sample
  chk_frame_set: assert property (
    @(posedge clock) disable iff (!rstn)
    ev && !ovr && char_stop_zero |=> stat_q[1])
    else $error("framing flag missing");

  // parity mismatch while parity is on
  chk_par_set: assert property (
    @(posedge clock) disable iff (!rstn)
    ev && !ovr && par_bad |=> stat_q[0])
    else $error("parity flag missing");

  // dma read alone clears full while service is on
  chk_dma_clear: assert property (
    @(posedge clock) disable iff (!rstn)
    dma_read && dma_on && rie && !prot && !ev |=> !stat_q[5])
    else $error("dma read left full");

  // dma read without a status read keeps error flags
  chk_dma_keep_err: assert property (
    @(posedge clock) disable iff (!rstn)
    dma_read && !armed_q |=> stat_q[3:0] == $past(stat_q[3:0]) ||
    $past(ev)) else $error("dma cleared errors");

  // service off: a data read alone never clears full
  chk_bus_keep_full: assert property (
    @(posedge clock) disable iff (!rstn)
    !rie && !armed_q && stat_q[5] |=> stat_q[5])
    else $error("full cleared in one step");

  // second step clears every error flag
  chk_two_step: assert property (
    @(posedge clock) disable iff (!rstn)
    step2 && !ev |=> stat_q[3:0] == 4'h0)
    else $error("errors survive two steps");

  // without data reads, stop mode freezes flags and the baud generator
  chk_stop_hold: assert property (
    @(posedge clock) disable iff (!rstn)
    halt && !any_dat && en |=> stat_q == $past(stat_q) && !baud_en)
    else $error("flag moved in stop");

  // protected break state blocks flag clears
  chk_prot_hold: assert property (
    @(posedge clock) disable iff (!rstn)
    prot && !ev && !idle_hit && !tx_done && en |=> stat_q == $past(stat_q))
    else $error("flag moved in break");

  // enabled module owns both pin directions
  chk_pin_dir: assert property (
    @(posedge clock) disable iff (!rstn)
    en |=> tx_pin_oe && !rx_pin_oe) else $error("pin override");

  // loop mode feeds the transmitter back in
  chk_loop_path: assert property (
    @(posedge clock) disable iff (!rstn)
    loop_on |=> rx_in == $past(tx_serial))
    else $error("loop path broken");

  // disabled module shows transmit flags, no transmitter request, no baud
  chk_dis_flags: assert property (
    @(posedge clock) disable iff (!rstn)
    !en |=> stat_q[7:6] == 2'h3 && !tx_irq && !baud_en)
    else $error("disable not applied");

  // standby silences every receiver request
  chk_standby: assert property (
    @(posedge clock) disable iff (!rstn)
    stby |=> !rx_irq && !dma_rx_req)
    else $error("request in standby");

  // main scenarios reached
  cov_overrun: cover property (@(posedge clock) ovr);
  cov_dma_read: cover property (@(posedge clock) dma_clr);
  cov_two_step: cover property (@(posedge clock) step2);
  cov_idle: cover property (@(posedge clock) idle_hit);
  cov_prot_read: cover property (@(posedge clock) prot && rd_dat);
endmodule

// >>> rtl/sci_flags_pkg.sv
// package: register map, field positions and reset values of the serial flag block
package sci_flags_pkg;
  // word offsets on the avalon bus (byte address = index * 4)
  localparam logic [2:0] OFS_CTRL1  = 3'h0;
  localparam logic [2:0] OFS_CTRL2  = 3'h1;
  localparam logic [2:0] OFS_CTRL3  = 3'h2;
  localparam logic [2:0] OFS_STAT1  = 3'h3;
  localparam logic [2:0] OFS_DATA   = 3'h4;
  localparam logic [2:0] OFS_BRKCTL = 3'h5;
  // control one fields
  localparam int C1_LOOP = 7;
  localparam int C1_EN   = 6;
  localparam int C1_M    = 4;
  localparam int C1_PEN  = 1;
  localparam int C1_PTY  = 0;
  // control two fields
  localparam int C2_TIE  = 7;
  localparam int C2_TCIE = 6;
  localparam int C2_RIE  = 5;
  localparam int C2_IDLE_LINE_IRQ_ENABLE = 4;
  localparam int C2_TE   = 3;
  localparam int C2_RE   = 2;
  localparam int C2_RWU  = 1;
  // control three fields
  localparam int C3_DMARX = 5;
  localparam int C3_OVERRUN_IRQ_ENABLE  = 3;
  localparam int C3_NOISE_IRQ_ENABLE  = 2;
  localparam int C3_FRAMING_IRQ_ENABLE  = 1;
  localparam int C3_PARITY_IRQ_ENABLE  = 0;
  // status one fields
  localparam int S1_TXE  = 7;
  localparam int S1_TC   = 6;
  localparam int S1_RXF  = 5;
  localparam int S1_IDLE = 4;
  localparam int S1_OR   = 3;
  localparam int S1_NF   = 2;
  localparam int S1_FE   = 1;
  localparam int S1_PE   = 0;
  // break flag control field
  localparam int BK_CLR_EN = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'hc0;
  // idle counts for 10 and 11 bit characters
  localparam logic [3:0] IDLE_BITS_8 = 4'ha;
  localparam logic [3:0] IDLE_BITS_9 = 4'hb;
endpackage

// >>> bench/rx_front.sv
// far side model: receiver front end delivering characters, and a dma
module rx_front (
  input  wire logic       clock,          // module clock
  input  wire logic       dma_rx_req,     // dma request level
  input  wire logic [7:0] dma_data,       // data register contents
  output logic            char_done,      // character complete pulse
  output logic [8:0]      char_data,      // character bits
  output logic            char_noise,     // noise seen on some bit
  output logic            char_stop_zero, // stop bit sampled low
  output logic            rx_bit_stb,     // one bit shifted in
  output logic            dma_read        // dma read of data register
);
  timeunit 1ns;
  timeprecision 1ps;
  int         n_dma = 0; // completed dma reads
  int         lat   = 1; // dma latency, raise it for a slow controller
  logic [7:0] dma_got;   // byte taken by the last dma read
  // quiet at time zero
  initial begin
    {char_done, char_noise, char_stop_zero, rx_bit_stb, dma_read} = '0;
    char_data = '0;
  end
  // qualifiers are only valid with the pulse, so scramble them afterwards
  task automatic send(input logic [8:0] d, input logic nz, input logic sz);
    @(posedge clock);
    char_done      <= 1'b1;
    char_data      <= d;
    char_noise     <= nz;
    char_stop_zero <= sz;
    @(posedge clock);
    char_done      <= 1'b0;
    char_data      <= ~d;
    char_noise     <= ~nz;
    char_stop_zero <= ~sz;
  endtask
  // n received bits, one strobe each
  task automatic bits(input int n);
    repeat (n) begin
      @(posedge clock);
      rx_bit_stb <= 1'b1;
      @(posedge clock);
      rx_bit_stb <= 1'b0;
    end
  endtask
  // dma answers a request after lat cycles, then lets the level drop
  // dma data read
  always begin
    @(posedge clock);
    if (dma_rx_req === 1'b1) begin
      repeat (lat) @(posedge clock);
      dma_read <= 1'b1;
      dma_got  <= dma_data;
      @(posedge clock);
      dma_read <= 1'b0;
      n_dma++;
      repeat (3) @(posedge clock);
    end
  end
endmodule

// >>> bench/tb.sv
// testbench: register accesses and receiver flag scenarios
`define B(x) (8'h01 << sci_flags_pkg::x)
`define chk(a, b) begin total_checks++; if ((a) !== (b)) begin \
  n_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] A1 = sci_flags_pkg::OFS_CTRL1;
  localparam logic [2:0] A2 = sci_flags_pkg::OFS_CTRL2;
  localparam logic [2:0] A3 = sci_flags_pkg::OFS_CTRL3;
  localparam logic [2:0] AS = sci_flags_pkg::OFS_STAT1;
  localparam logic [2:0] AD = sci_flags_pkg::OFS_DATA;
  localparam logic [2:0] AB = sci_flags_pkg::OFS_BRKCTL;
  localparam logic [7:0] ST = sci_flags_pkg::STAT_RST;
  localparam logic [7:0] EN = `B(C1_EN);
  localparam logic [7:0] TRE = `B(C2_TE) | `B(C2_RE);
  localparam logic [7:0] RIE = `B(C2_RIE);
  localparam logic [7:0] DMA = `B(C3_DMARX);
  localparam logic [7:0] RXF = `B(S1_RXF);
  localparam logic [7:0] EIE [3] = '{`B(C3_NOISE_IRQ_ENABLE), `B(C3_FRAMING_IRQ_ENABLE), `B(C3_PARITY_IRQ_ENABLE)};
  localparam logic [7:0] EFL [3] = '{`B(S1_NF), `B(S1_FE), `B(S1_PE)};
  logic        clock = 1'b0, rstn = 1'b0;
  logic [2:0]  avs_address = '0;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = '0, avs_readdata, rv;
  logic        avs_waitrequest, dma_read, char_done, char_noise;
  logic [7:0]  dma_data;
  logic [8:0]  char_data;
  logic        char_stop_zero, rx_bit_stb, rx_in, tx_pin_oe, rx_pin_oe;
  logic        tx_serial = 1'b0, tx_done = 1'b0, rx_pin = 1'b1;
  logic        port_dir_tx = 1'b0, port_dir_rx = 1'b1, wake_clear = 1'b0;
  logic        stop_mode = 1'b0, dbg_break = 1'b0;
  logic        baud_en, rx_irq, err_irq, tx_irq, dma_rx_req;
  int          n_errors = 0, total_checks = 0, t;
  // 200 mhz clock
  always #2.5 clock = ~clock;
  sci_flags sci_flags_i (.*);
  rx_front rx_front_i (.*);
  // verdict, also reached from the watchdog
  task automatic finish_test;
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // settle: n edges, then look just after the last one
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic acc(input logic [2:0] a, input logic w, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_read      <= ~w;
    avs_write     <= w;
    avs_writedata <= {24'h0, d};
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && k < 50) begin
      k++;
      @(posedge clock);
    end
    if (k == 50) `chk(1'b0, 1'b1)
    rv = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00);
    `chk(rv, {24'h0, e})
  endtask
  // bounded wait for the dma model to finish n reads
  task automatic waitdma(input int n);
    for (int k = 0; k < 100 && rx_front_i.n_dma < n; k++) cyc(1);
    `chk(rx_front_i.n_dma, n)
  endtask
  // watchdog: the sequence needs a few hundred cycles
  initial begin
    #50000;
    n_errors++;
    finish_test;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rdc(A1, sci_flags_pkg::CTRL_RST);
    rdc(AS, ST);
    acc(3'h7, 1'b1, 8'hff);
    rdc(3'h6, 8'h00);
    acc(A1, 1'b1, EN);
    acc(A2, 1'b1, TRE);
    cyc(3);
    `chk({tx_pin_oe, rx_pin_oe, baud_en}, 3'b101)
    // loop mode follows the transmitter, normal mode the pin
    acc(A1, 1'b1, EN | `B(C1_LOOP));
    cyc(4);
    `chk(rx_in, 1'b0)
    @(posedge clock);
    tx_serial <= 1'b1;
    cyc(4);
    `chk(rx_in, 1'b1)
    acc(A1, 1'b1, EN);
    rx_pin <= 1'b0;
    cyc(5);
    `chk(rx_in, 1'b0)
    @(posedge clock);
    rx_pin <= 1'b1;
    // cpu path, then overrun keeps the first byte
    acc(A2, 1'b1, TRE | RIE);
    rx_front_i.send(9'h05a, 1'b0, 1'b0);
    cyc(3);
    `chk({rx_irq, dma_rx_req}, 2'b10)
    rdc(AS, ST | RXF);
    rdc(AD, 8'h5a);
    cyc(2);
    `chk(rx_irq, 1'b0)
    rx_front_i.send(9'h011, 1'b0, 1'b0);
    rx_front_i.send(9'h022, 1'b0, 1'b0);
    acc(A3, 1'b1, `B(C3_OVERRUN_IRQ_ENABLE));
    cyc(2);
    `chk(err_irq, 1'b1)
    rdc(AS, ST | RXF | `B(S1_OR));
    rdc(AD, 8'h11);
    rdc(AS, ST);
    `chk(err_irq, 1'b0)
    // noise, framing and parity each raise the error request only with their own enable
    acc(A1, 1'b1, EN | `B(C1_PEN));
    for (int i = 0; i < 3; i++) begin
      rx_front_i.send(i == 2 ? 9'h001 : 9'h003, i == 0, i == 1);
      acc(A3, 1'b1, 8'h0f & ~EIE[i]);
      cyc(2);
      `chk(err_irq, 1'b0)
      acc(A3, 1'b1, EIE[i]);
      cyc(2);
      `chk(err_irq, 1'b1)
      rdc(AS, ST | RXF | EFL[i]);
      acc(AD, 1'b0, 8'h00);
    end
    acc(A1, 1'b1, EN);
    // idle after exactly ten ones, then the receiver request routing
    acc(A2, 1'b1, TRE | `B(C2_IDLE_LINE_IRQ_ENABLE));
    rx_front_i.bits(9);
    cyc(2);
    rdc(AS, ST);
    rx_front_i.bits(1);
    cyc(2);
    rdc(AS, ST | `B(S1_IDLE));
    `chk(rx_irq, 1'b1)
    acc(A2, 1'b1, TRE | `B(C2_IDLE_LINE_IRQ_ENABLE) | `B(C2_RWU));
    cyc(2);
    `chk(rx_irq, 1'b0)
    @(posedge clock);
    wake_clear <= 1'b1;
    @(posedge clock);
    wake_clear <= 1'b0;
    cyc(2);
    `chk(rx_irq, 1'b1)
    acc(A3, 1'b1, DMA);
    cyc(2);
    `chk(rx_irq, 1'b0)
    // service dropped around error handling, pending byte kept for dma
    acc(A2, 1'b1, TRE);
    acc(AD, 1'b0, 8'h00);
    rx_front_i.send(9'h0a5, 1'b1, 1'b0);
    cyc(3);
    `chk({dma_rx_req, rx_irq}, 2'b00)
    t = rx_front_i.n_dma;
    acc(A2, 1'b1, TRE | RIE);
    waitdma(t + 1);
    `chk(rx_front_i.dma_got, 8'ha5)
    rdc(AS, ST | `B(S1_NF));
    rx_front_i.send(9'h03c, 1'b0, 1'b0);
    waitdma(t + 2);
    rdc(AS, ST);
    // stop mode drops characters and keeps registers, then resumes
    @(posedge clock);
    stop_mode <= 1'b1;
    cyc(3);
    `chk(baud_en, 1'b0)
    rx_front_i.send(9'h077, 1'b0, 1'b0);
    cyc(2);
    rdc(AS, ST);
    stop_mode <= 1'b0;
    cyc(3);
    rdc(A2, TRE | RIE);
    `chk(baud_en, 1'b1)
    // break state protects flags, first step survives the break
    acc(A3, 1'b1, 8'h00);
    rx_front_i.send(9'h003, 1'b0, 1'b1);
    acc(AS, 1'b0, 8'h00);
    dbg_break <= 1'b1;
    cyc(4);
    acc(AD, 1'b0, 8'h00);
    rdc(AS, ST | RXF | `B(S1_FE));
    dbg_break <= 1'b0;
    cyc(4);
    rdc(AD, 8'h03);
    rdc(AS, ST);
    // with clear-enable set, a clear inside the break sticks
    rx_front_i.send(9'h003, 1'b0, 1'b1);
    acc(AB, 1'b1, `B(BK_CLR_EN));
    dbg_break <= 1'b1;
    cyc(4);
    acc(AS, 1'b0, 8'h00);
    acc(AD, 1'b0, 8'h00);
    dbg_break <= 1'b0;
    cyc(4);
    rdc(AS, ST);
    // disabling the module silences the transmitter request
    acc(A2, 1'b1, TRE | RIE | `B(C2_TIE));
    cyc(2);
    `chk(tx_irq, 1'b1)
    acc(A1, 1'b1, 8'h00);
    cyc(2);
    `chk({tx_irq, baud_en}, 2'b00)
    rdc(AS, ST);
    finish_test;
  end
endmodule
